// ===== design/timer16_pkg.sv
// Purpose: Constants for the sixteen-bit timer/counter.
// Assumes: One core clock, byte-wide register strobes from the core.
// Notes:   Control bits arrive as plain ports; there is no register bus.
//
// How it works
// - Timer clock is divided by 1, 2, 4 or 8 per prescale select.
// - Prescaler is hidden from software; a count byte write clears it, except a high-byte write in wide access mode.
// - Unsynchronised mode counts the external clock without the synchroniser.
// - External asynchronous source keeps counting in sleep; overflow wakes.
// - Mode switches may lose or add one increment.
// - Byte reads return a valid count while the external clock runs.
// - Wide access routes high-byte accesses through a high-byte buffer.
// - Wide access: low read snapshots high byte; high read returns it.
// - Wide access: buffer high first, low write loads both bytes.
// - Wide access: high-byte write leaves the prescaler alone.
package timer16_pkg;

    localparam int COUNT_W = 16;
    localparam int BYTE_W  = 8;
    localparam int PSC_W   = 3;

    typedef logic [1:0] prescale_select_t;

    localparam prescale_select_t PSC_DIV1 = 2'h0;
    localparam prescale_select_t PSC_DIV2 = 2'h1;
    localparam prescale_select_t PSC_DIV4 = 2'h2;
    localparam prescale_select_t PSC_DIV8 = 2'h3;

    localparam logic [PSC_W-1:0]   PSC_LAST_DIV1 = 3'h0;
    localparam logic [PSC_W-1:0]   PSC_LAST_DIV2 = 3'h1;
    localparam logic [PSC_W-1:0]   PSC_LAST_DIV4 = 3'h3;
    localparam logic [PSC_W-1:0]   PSC_LAST_DIV8 = 3'h7;

    localparam logic [PSC_W-1:0]   PSC_RESET   = 3'h0;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_MAX   = 16'hFFFF;
    localparam logic [BYTE_W-1:0]  BYTE_RESET  = 8'h00;

endpackage : timer16_pkg

// ===== design/timer16.sv
// Purpose: Sixteen-bit timer/counter with prescaler and wide access mode.
// Assumes: All inputs synchronous to core_clk_i except ext_clk_i in
//          unsynchronised mode; core strobes are one cycle wide.
// Notes:   Read data appears one cycle after a read strobe.
`timescale 1ns/10ps
module timer16 (
    input  wire logic                          core_clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          timer_on_i,
    input  wire timer16_pkg::prescale_select_t prescale_select_i,
    input  wire logic                          async_mode_i,
    input  wire logic                          ext_source_i,
    input  wire logic                          ext_clk_i,
    input  wire logic                          wide_access_enable_i,
    input  wire logic                          sleep_i,
    input  wire logic                          wr_low_i,
    input  wire logic                          wr_high_i,
    input  wire logic                          rd_low_i,
    input  wire logic                          rd_high_i,
    input  wire logic [7:0]                    wdata_i,
    input  wire logic                          ovf_clear_i,
    output logic      [7:0]                    rdata_o,
    output logic                               ovf_flag_o,
    output logic                               wake_o
);
    import timer16_pkg::*;

    logic [COUNT_W-1:0] count_reg;
    logic [BYTE_W-1:0]  hbuf_reg;
    logic [PSC_W-1:0]   psc_reg;
    logic [BYTE_W-1:0]  rdata_reg;
    logic               ovf_reg;
    logic               wake_reg;
    logic               sync1_reg;
    logic               sync2_reg;
    logic               sync3_reg;
    logic               raw_prev_reg;
    logic               sync_edge;
    logic               raw_edge;
    logic               free_run;
    logic               run_ok;
    logic               src_tick;
    logic               inc;
    logic               psc_clear;
    logic               count_write;
    logic               wrap;

    function automatic logic [PSC_W-1:0] psc_last(
        input prescale_select_t sel
    );
        case (sel)
            PSC_DIV1: psc_last = PSC_LAST_DIV1;
            PSC_DIV2: psc_last = PSC_LAST_DIV2;
            PSC_DIV4: psc_last = PSC_LAST_DIV4;
            default:  psc_last = PSC_LAST_DIV8;
        endcase
    endfunction : psc_last

    // Synchronised path: three stages so the edge detector never looks at
    // the first flop, which may be metastable.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= ext_clk_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Unsynchronised path: the raw pin feeds the edge detector directly.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            raw_prev_reg <= 1'b0;
        end else begin
            raw_prev_reg <= ext_clk_i;
        end
    end

    assign sync_edge = sync2_reg & ~sync3_reg;
    assign raw_edge  = ext_clk_i & ~raw_prev_reg;
    // The two paths differ in latency, so a mode switch can drop or repeat
    // one edge; this is accepted rather than adding merge logic.
    assign free_run  = ext_source_i & async_mode_i;

    // Only an external unsynchronised source keeps running in sleep.
    assign run_ok   = timer_on_i & (~sleep_i | free_run);
    always_comb begin
        if (!ext_source_i) begin
            src_tick = run_ok;
        end else if (async_mode_i) begin
            src_tick = run_ok & raw_edge;
        end else begin
            src_tick = run_ok & sync_edge;
        end
    end

    // Compare with >= so that a smaller select, taken while the prescaler
    // sits above its new end value, does not stall until the counter wraps.
    assign inc = src_tick & (psc_reg >= psc_last(prescale_select_i));

    // A high-byte write clears the prescaler only outside wide mode.
    assign psc_clear = wr_low_i
                     | (wr_high_i & ~wide_access_enable_i);

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            psc_reg <= PSC_RESET;
        end else if (psc_clear) begin
            psc_reg <= PSC_RESET;
        end else if (inc) begin
            psc_reg <= PSC_RESET;
        end else if (src_tick) begin
            psc_reg <= psc_reg + 3'h1;
        end
    end

    assign count_write = wr_low_i | (wr_high_i & ~wide_access_enable_i);
    assign wrap        = inc & ~count_write & (count_reg == COUNT_MAX);

    // A write wins over a coincident increment; firmware is expected to
    // stop the timer first, so the collision only matters when it does not.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            count_reg <= COUNT_RESET;
        end else if (wr_low_i && wide_access_enable_i) begin
            count_reg <= {hbuf_reg, wdata_i};
        end else if (count_write) begin
            if (wr_low_i) begin
                count_reg[7:0] <= wdata_i;
            end
            if (wr_high_i) begin
                count_reg[15:8] <= wdata_i;
            end
        end else if (inc) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            hbuf_reg <= BYTE_RESET;
        end else if (wide_access_enable_i && wr_high_i) begin
            hbuf_reg <= wdata_i;
        end else if (wide_access_enable_i && rd_low_i) begin
            hbuf_reg <= count_reg[15:8];
        end
    end

    // Reads come from the live count held in the core domain, so a value
    // read while the external clock runs is always a settled one.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= BYTE_RESET;
        end else if (rd_low_i) begin
            rdata_reg <= count_reg[7:0];
        end else if (rd_high_i) begin
            rdata_reg <= wide_access_enable_i ? hbuf_reg
                                              : count_reg[15:8];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ovf_reg <= 1'b0;
        end else if (wrap) begin
            ovf_reg <= 1'b1;
        end else if (ovf_clear_i) begin
            ovf_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= wrap & sleep_i;
        end
    end

    assign rdata_o    = rdata_reg;
    assign ovf_flag_o = ovf_reg;
    assign wake_o     = wake_reg;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_wrap_to_zero: assert property (
        wrap |=> (count_reg == COUNT_RESET) && ovf_flag_o
    ) else $error("count did not wrap to zero with flag set");

    a_flag_sticky: assert property (
        ovf_flag_o && !ovf_clear_i |=> ovf_flag_o
    ) else $error("overflow flag dropped without a clear");

    a_flag_set_wins: assert property (
        wrap && ovf_clear_i |=> ovf_flag_o
    ) else $error("clear beat a coincident overflow");

    a_low_write_psc: assert property (
        wr_low_i |=> psc_reg == PSC_RESET
    ) else $error("low write did not clear prescaler");

    a_high_keep_psc: assert property (
        wide_access_enable_i && wr_high_i && !wr_low_i && !src_tick
        |=> psc_reg == $past(psc_reg)
    ) else $error("wide high write touched prescaler");

    a_wide_load: assert property (
        wide_access_enable_i && wr_low_i
        |=> count_reg == {$past(hbuf_reg), $past(wdata_i)}
    ) else $error("wide low write did not load both bytes");

    a_wide_snapshot: assert property (
        wide_access_enable_i && rd_low_i && !wr_high_i
        |=> hbuf_reg == $past(count_reg[15:8])
    ) else $error("low read did not snapshot high byte");

    a_wide_high_rd: assert property (
        wide_access_enable_i && rd_high_i && !rd_low_i
        |=> rdata_o == $past(hbuf_reg)
    ) else $error("wide high read bypassed the buffer");

    a_div8_spacing: assert property (
        inc && prescale_select_i == PSC_DIV8 && !psc_clear
        |=> !inc [*7]
    ) else $error("divide by eight incremented too soon");

    a_sleep_hold: assert property (
        sleep_i && !free_run && !wr_low_i && !wr_high_i
        |=> count_reg == $past(count_reg)
    ) else $error("count moved in sleep without free-running source");

    a_wake_on_ovf: assert property (
        wrap && sleep_i |=> wake_o
    ) else $error("overflow in sleep gave no wake");

    // The checks below watch the counting path from both ends: the tick and
    // prescaler that feed an increment, the count and flag it leaves, and the wake and read-back outputs.
    a_count_step: assert property (
        inc && !count_write
        |=> count_reg == $past(count_reg) + 16'h0001
    ) else $error("increment did not add exactly one");

    a_count_idle: assert property (
        !timer_on_i && !wr_low_i && !wr_high_i |=> count_reg == $past(count_reg)
    ) else $error("count moved while the timer was off");

    a_flag_clears: assert property (
        ovf_clear_i && !wrap |=> !ovf_flag_o
    ) else $error("clear left the overflow flag set");

    a_flag_source: assert property (
        $rose(ovf_flag_o) |-> $past(wrap)
    ) else $error("overflow flag rose without a wrap");

    a_div1_every: assert property (
        src_tick && prescale_select_i == PSC_DIV1 |-> inc
    ) else $error("divide by one skipped a tick");

    a_div2_spacing: assert property (
        inc && prescale_select_i == PSC_DIV2 && !psc_clear |=> !inc
    ) else $error("divide by two incremented too soon");

    a_high_write_psc: assert property (
        !wide_access_enable_i && wr_high_i |=> psc_reg == PSC_RESET
    ) else $error("high write outside wide mode kept prescaler");

    a_async_tick: assert property (
        ext_source_i && async_mode_i
        |-> src_tick == (run_ok && raw_edge)
    ) else $error("unsynchronised source tick mismatch");

    a_sync_tick: assert property (
        ext_source_i && !async_mode_i && !sync_edge |-> !src_tick
    ) else $error("synchronised source ticked without an edge");

    a_wake_awake: assert property (
        !sleep_i |=> !wake_o
    ) else $error("wake pulse while awake");

    a_rd_low_data: assert property (
        rd_low_i |=> rdata_o == $past(count_reg[7:0])
    ) else $error("low read returned a stale byte");

    a_narrow_high_rd: assert property (
        !wide_access_enable_i && rd_high_i && !rd_low_i
        |=> rdata_o == $past(count_reg[15:8])
    ) else $error("narrow high read did not return the live byte");

    a_wide_high_hold: assert property (
        wide_access_enable_i && wr_high_i && !wr_low_i && !inc
        |=> count_reg == $past(count_reg)
    ) else $error("wide high write reached the live count");

    c_overflow:   cover property (wrap);
    c_wide_read:  cover property (wide_access_enable_i && rd_low_i
                                  ##[1:4] rd_high_i);
    c_wide_write: cover property (wide_access_enable_i && wr_high_i
                                  ##[1:4] wr_low_i);
    c_sleep_wake: cover property (wake_o);
    c_async_sleep: cover property (free_run && sleep_i && inc);

endmodule : timer16

// ===== verif/ext_clock_source.sv
// Purpose: Far-side clock source that feeds the timer's external input.
// Assumes: Edges are counted by the timer on ext_clk_o rising edges.
// Notes:   Holds low between bursts so no stray edge is ever counted.
`timescale 1ns/10ps
module ext_clock_source (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       start_i,
    input  wire logic [3:0] n_edges_i,
    output logic            ext_clk_o,
    output logic            busy_o
);
    logic [4:0] left_reg;
    logic       div_reg;

    assign busy_o = (left_reg != 5'h00);

    // Two core cycles high and two low, so sync mode sees every level.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            left_reg  <= 5'h00;
            div_reg   <= 1'b0;
            ext_clk_o <= 1'b0;
        end else if (start_i && !busy_o) begin
            left_reg <= {n_edges_i, 1'b0};
            div_reg  <= 1'b0;
        end else if (busy_o) begin
            div_reg <= ~div_reg;
            if (div_reg) begin
                ext_clk_o <= ~ext_clk_o;
                left_reg  <= left_reg - 5'h01;
            end
        end
    end
endmodule : ext_clock_source

// ===== verif/tb.sv
// Purpose: Self-checking bench for the sixteen-bit timer/counter.
// Assumes: Inputs change on the falling edge of the core clock.
// Notes:   The timer is stopped before every count write.
`timescale 1ns/10ps
module tb;
    import timer16_pkg::*;
    logic clk = 0, rst_n = 0, on = 0, async_m = 0, ext_src = 0, wide = 0;
    logic slp = 0, wr_lo = 0, wr_hi = 0, rd_lo = 0, rd_hi = 0, clr = 0;
    logic start = 0, ext_clk, busy, ovf, wake;
    logic [7:0] wdata = 8'h00, rdata, b;
    logic [3:0] n_edges = 4'h0;
    prescale_select_t psel = PSC_DIV1;
    logic [15:0] v;
    int n_mismatch = 0, checks_done = 0, n_wake = 0;

    always #5 clk = ~clk;
    // Sampled on the falling edge so the registered pulse is seen once.
    always @(negedge clk) if (wake === 1'b1) n_wake++;

    timer16 u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .timer_on_i(on),
        .prescale_select_i(psel), .async_mode_i(async_m),
        .ext_source_i(ext_src), .ext_clk_i(ext_clk),
        .wide_access_enable_i(wide), .sleep_i(slp), .wr_low_i(wr_lo),
        .wr_high_i(wr_hi), .rd_low_i(rd_lo), .rd_high_i(rd_hi),
        .wdata_i(wdata), .ovf_clear_i(clr), .rdata_o(rdata),
        .ovf_flag_o(ovf), .wake_o(wake));
    ext_clock_source u_src (.core_clk_i(clk), .rst_n_i(rst_n),
        .start_i(start), .n_edges_i(n_edges), .ext_clk_o(ext_clk),
        .busy_o(busy));

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse

    task automatic wr(input logic hi, input logic [7:0] d);
        wdata = d;
        if (hi) pulse(wr_hi);
        else pulse(wr_lo);
    endtask : wr

    task automatic rd(input logic hi, output logic [7:0] d);
        if (hi) pulse(rd_hi);
        else pulse(rd_lo);
        d = rdata;
    endtask : rd

    task automatic set_count(input logic [15:0] c);
        wr(1'b1, c[15:8]);
        wr(1'b0, c[7:0]);
    endtask : set_count

    task automatic get_count(output logic [15:0] c);
        rd(1'b0, c[7:0]);
        rd(1'b1, c[15:8]);
    endtask : get_count

    task automatic run(input int n);
        on = 1'b1;
        repeat (n) @(negedge clk);
        on = 1'b0;
        repeat (2) @(negedge clk);
    endtask : run

    task automatic t_prescale;
        // Descending order leaves a prescaler residue that a write must clear.
        for (int s = 3; s >= 0; s--) begin
            psel = prescale_select_t'(s);
            set_count(16'h0000);
            run(13);
            get_count(v);
            check("prescaled count", v, 16'(13 >> s));
        end
    endtask : t_prescale

    task automatic t_overflow;
        psel = PSC_DIV1;
        set_count(16'hFFFF);
        check("flag before wrap", {15'h0, ovf}, 16'h0000);
        run(1);
        check("flag after wrap", {15'h0, ovf}, 16'h0001);
        get_count(v);
        check("wrapped count", v, 16'h0000);
        pulse(clr);
        check("flag cleared", {15'h0, ovf}, 16'h0000);
        check("wake awake", 16'(n_wake), 16'h0000);
    endtask : t_overflow

    task automatic t_rollover;
        psel = PSC_DIV1;
        set_count(16'h00FE);
        on = 1'b1;
        rd(1'b1, b);
        rd(1'b0, v[7:0]);
        rd(1'b1, v[15:8]);
        // A changed high byte means the low read straddled a rollover.
        if (v[15:8] !== b) rd(1'b0, v[7:0]);
        on = 1'b0;
        check("rollover read", v, 16'h0101);
    endtask : t_rollover

    task automatic t_ext_sync;
        ext_src = 1'b1;
        set_count(16'h0000);
        on = 1'b1;
        ext_burst(4'h3);
        get_count(v);
        check("sync external count", v, 16'h0003);
        on = 1'b0;
    endtask : t_ext_sync

    task automatic ext_burst(input logic [3:0] n);
        n_edges = n;
        pulse(start);
        for (int i = 0; i < 100 && busy === 1'b1; i++) @(negedge clk);
        repeat (4) @(negedge clk);
    endtask : ext_burst

    task automatic t_sleep;
        ext_src = 1'b1;
        slp = 1'b1;
        set_count(16'hFFFE);
        on = 1'b1;
        ext_burst(4'h2);
        get_count(v);
        check("sync sleep count", v, 16'hFFFE);
        on = 1'b0;
        async_m = 1'b1;
        set_count(16'hFFFE);
        on = 1'b1;
        ext_burst(4'h2);
        get_count(v);
        check("async sleep count", v, 16'h0000);
        check("wake pulses", 16'(n_wake), 16'h0001);
        check("sleep flag", {15'h0, ovf}, 16'h0001);
        {on, slp, async_m, ext_src} = 4'h0;
        pulse(clr);
    endtask : t_sleep

    task automatic t_wide;
        wide = 1'b1;
        set_count(16'hABCD);
        get_count(v);
        check("wide write", v, 16'hABCD);
        set_count(16'h00FF);
        rd(1'b0, b);
        run(1);
        rd(1'b1, b);
        check("snapshot high", {8'h00, b}, 16'h0000);
        get_count(v);
        check("wide read", v, 16'h0100);
        psel = PSC_DIV2;
        set_count(16'h0000);
        run(1);
        wr(1'b1, 8'h00);
        run(1);
        get_count(v);
        check("prescaler kept", v, 16'h0001);
        wide = 1'b0;
    endtask : t_wide

    task automatic test_done;
        if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_prescale();
        t_overflow();
        t_rollover();
        t_ext_sync();
        t_sleep();
        t_wide();
        test_done();
    end
endmodule : tb
